//--- hdl/asfb_pkg.sv
// constants shared by the serial api status frame builder
package asfb_pkg;

	// ****************************************************************
	// frame layout
	// ****************************************************************
	localparam logic [7:0]  ASFB_DELIMITER      = 8'h7E;
	localparam logic [7:0]  ASFB_TYPE_REMOTE    = 8'h97;
	localparam logic [7:0]  ASFB_TYPE_EXTSTAT   = 8'h98;
	localparam logic [7:0]  ASFB_CODE_SESS_UP   = 8'h3B;
	localparam logic [7:0]  ASFB_CODE_SESS_END  = 8'h3C;
	localparam logic [7:0]  ASFB_CODE_AUTH_FAIL = 8'h3D;
	localparam logic [7:0]  ASFB_CSUM_BASE      = 8'hFF;
	localparam int          ASFB_BODY_BYTES     = 24;
	localparam int          ASFB_PARAM_BYTES    = 8;
	localparam int          ASFB_JOIN_BYTES     = 8;
	localparam logic [15:0] ASFB_LEN_REMOTE     = 16'h000F;
	localparam logic [15:0] ASFB_LEN_SESS_UP    = 16'h000D;
	localparam logic [15:0] ASFB_LEN_SESS_OTHER = 16'h000B;
	localparam logic [15:0] ASFB_LEN_JOIN       = 16'h0002;

	// ****************************************************************
	// command status and session end reason encodings
	// ****************************************************************
	localparam logic [7:0]  ASFB_CST_OK         = 8'h00;
	localparam logic [7:0]  ASFB_CST_ERROR      = 8'h01;
	localparam logic [7:0]  ASFB_CST_BAD_CMD    = 8'h02;
	localparam logic [7:0]  ASFB_CST_BAD_PARAM  = 8'h03;
	localparam logic [7:0]  ASFB_CST_TX_FAIL    = 8'h04;
	localparam logic [7:0]  ASFB_RSN_PEER       = 8'h00;
	localparam logic [7:0]  ASFB_RSN_TIMEOUT    = 8'h01;
	localparam logic [7:0]  ASFB_RSN_BAD_CTR    = 8'h02;
	localparam logic [7:0]  ASFB_RSN_CTR_OVF    = 8'h03;
	localparam logic [7:0]  ASFB_RSN_NO_MEM     = 8'h04;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0]  ASFB_OFS_CTRL       = 8'h00;
	localparam logic [7:0]  ASFB_OFS_STATUS     = 8'h04;
	localparam logic [7:0]  ASFB_OFS_MASK       = 8'h08;
	localparam logic [7:0]  ASFB_OFS_STATE      = 8'h0C;
	localparam logic [7:0]  ASFB_OFS_COUNT      = 8'h10;
	localparam int          ASFB_CTRL_EXT_SEC   = 0;
	localparam int          ASFB_CTRL_VERBOSE   = 1;
	localparam int          ASFB_EV_SENT        = 0;
	localparam int          ASFB_EV_SUPPRESSED  = 1;
	localparam int          ASFB_EV_FILTERED    = 2;
	localparam int          ASFB_EV_OVERRUN     = 3;
	localparam logic [1:0]  ASFB_CTRL_RESET     = 2'h0;
	localparam logic [3:0]  ASFB_MASK_RESET     = 4'h0;

	typedef enum logic [1:0] {
		ASFB_SESS_UP_K,
		ASFB_SESS_END_K,
		ASFB_AUTH_FAIL_K
	} asfb_sess_type;

endpackage

//--- hdl/asfb_byte_emitter.sv
// output byte register with handshake and running checksum
`timescale 1ns/1ps
module asfb_byte_emitter
	import asfb_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire logic       load,
	input  wire logic [7:0] byte_in,
	input  wire logic       add_sum,
	input  wire logic       clear_sum,
	input  wire logic       tx_ready,
	output logic            can_load,
	output logic [7:0]      checksum,
	output logic [7:0]      tx_data,
	output logic            tx_valid
);

	logic [7:0] sum_reg;

	// a new byte may replace the held one once the receiver has it
	assign can_load = !tx_valid || tx_ready;
	assign checksum = ASFB_CSUM_BASE - sum_reg;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			tx_data  <= 8'h00;
			tx_valid <= 1'b0;
		end else if (load && can_load) begin
			tx_data  <= byte_in;
			tx_valid <= 1'b1;
		end else if (tx_ready) begin
			tx_valid <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n || clear_sum) begin
			sum_reg <= 8'h00;
		end else if (load && can_load && add_sum) begin
			sum_reg <= sum_reg + byte_in;
		end
	end

endmodule

//--- hdl/asfb_frame_builder.sv
// serial api frame builder: remote command response and extended modem status
//
// Functional notes
// - last byte is ff minus low byte of sum from frame type onward.
// - parameter change response ends after command status, no parameter bytes.
// - query response carries current value after the command status byte.
// - extended modem status frame uses frame type 98.
// - extended status puts status code at offset four, then optional data.
// - sixteen bit length at offset one counts bytes between length and checksum.
// - every frame opens with a start delimiter byte.
// - secure session status frames only when extended api options allow.
// - session established carries client address, options byte, timeout.
// - session ended carries peer address then a reason byte.
// - reasons: 00 peer, 01 timeout, 02 bad counter, 03 overflow, 04 memory.
// - authentication failure carries client address then an error byte.
// - remote response is type 97 echoing the request frame identifier.
// - join progress frames only when joining device controls enable verbose.
// - command status 00 ok, 01 error, 02 bad command, 03 bad parameter, 04 fail.
// - no remote response at all when the request identifier is zero.
`timescale 1ns/1ps
module asfb_frame_builder
	import asfb_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	output logic             irq,
	input  wire logic        rcr_req,
	input  wire logic [7:0]  rcr_frame_id,
	input  wire logic [63:0] rcr_src64,
	input  wire logic [15:0] rcr_src16,
	input  wire logic [15:0] rcr_command,
	input  wire logic [2:0]  rcr_status,
	input  wire logic        rcr_query,
	input  wire logic [3:0]  rcr_param_len,
	input  wire logic [63:0] rcr_param,
	input  wire logic        sess_req,
	input  wire logic [1:0]  sess_kind,
	input  wire logic [63:0] sess_addr,
	input  wire logic [7:0]  sess_options,
	input  wire logic [15:0] sess_timeout,
	input  wire logic [2:0]  sess_reason,
	input  wire logic [7:0]  sess_error,
	input  wire logic        join_req,
	input  wire logic [7:0]  join_code,
	input  wire logic [3:0]  join_len,
	input  wire logic [63:0] join_data,
	input  wire logic        tx_ready,
	output logic [7:0]       tx_data,
	output logic             tx_valid,
	output logic             busy
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	// command status codes
	function automatic logic [7:0] cmd_status_byte(input logic [2:0] code);
		case (code)
			3'h0:    cmd_status_byte = ASFB_CST_OK;
			3'h1:    cmd_status_byte = ASFB_CST_ERROR;
			3'h2:    cmd_status_byte = ASFB_CST_BAD_CMD;
			3'h3:    cmd_status_byte = ASFB_CST_BAD_PARAM;
			3'h4:    cmd_status_byte = ASFB_CST_TX_FAIL;
			default: cmd_status_byte = ASFB_CST_ERROR;
		endcase
	endfunction

	function automatic logic [7:0] reason_byte(input logic [2:0] code);
		case (code)
			3'h0:    reason_byte = ASFB_RSN_PEER;
			3'h1:    reason_byte = ASFB_RSN_TIMEOUT;
			3'h2:    reason_byte = ASFB_RSN_BAD_CTR;
			3'h3:    reason_byte = ASFB_RSN_CTR_OVF;
			3'h4:    reason_byte = ASFB_RSN_NO_MEM;
			default: reason_byte = ASFB_RSN_PEER;
		endcase
	endfunction

	// clamps a byte count to the eight the field can hold
	function automatic logic [3:0] clamp_len(input logic [3:0] n);
		clamp_len = (n > 4'(ASFB_PARAM_BYTES)) ? 4'(ASFB_PARAM_BYTES) : n;
	endfunction

	typedef enum {
		ST_IDLE,
		ST_DELIM,
		ST_LEN_HI,
		ST_LEN_LO,
		ST_BODY,
		ST_CSUM
	} asfb_state_type;

	localparam int BODY_W = ASFB_BODY_BYTES * 8;

	// ****************************************************************
	// registers
	// ****************************************************************
	logic [1:0]        ctrl_reg;
	logic [3:0]        status_reg;
	logic [3:0]        mask_reg;
	logic [15:0]       count_reg;
	logic [3:0]        events;
	logic              rcr_pend_reg;
	logic [7:0]        rcr_fid_reg;
	logic [63:0]       rcr_src64_reg;
	logic [15:0]       rcr_src16_reg;
	logic [15:0]       rcr_cmd_reg;
	logic [7:0]        rcr_status_reg;
	logic [3:0]        rcr_plen_reg;
	logic [63:0]       rcr_param_reg;
	logic              sess_pend_reg;
	logic [7:0]        sess_code_reg;
	logic [63:0]       sess_addr_reg;
	logic [23:0]       sess_tail_reg;
	logic [15:0]       sess_len_reg;
	logic              join_pend_reg;
	logic [7:0]        join_code_reg;
	logic [3:0]        join_len_reg;
	logic [63:0]       join_data_reg;
	asfb_state_type    state_reg;
	logic [BODY_W-1:0] body_reg;
	logic [15:0]       len_reg;
	logic [15:0]       left_reg;
	logic              em_load;
	logic [7:0]        em_byte;
	logic              em_add;
	logic              em_clear;
	logic              em_can;
	logic [7:0]        em_csum;
	logic              start_rcr;
	logic              start_sess;
	logic              start_join;
	logic              frame_done;
	logic              rcr_drop;
	logic              filt_drop;
	logic              overrun;

	// ****************************************************************
	// request capture
	// ****************************************************************
	// the engine is busy for the whole frame, so each source holds one request
	assign start_rcr  = (state_reg == ST_IDLE) && rcr_pend_reg;
	assign start_sess = (state_reg == ST_IDLE) && !rcr_pend_reg && sess_pend_reg;
	assign start_join = (state_reg == ST_IDLE) && !rcr_pend_reg && !sess_pend_reg && join_pend_reg;
	assign rcr_drop   = rcr_req && (rcr_frame_id == 8'h00);
	assign filt_drop  = (sess_req && !ctrl_reg[ASFB_CTRL_EXT_SEC]) ||
	                    (join_req && !ctrl_reg[ASFB_CTRL_VERBOSE]);
	assign overrun    = (rcr_req && !rcr_drop && rcr_pend_reg && !start_rcr) ||
	                    (sess_req && ctrl_reg[ASFB_CTRL_EXT_SEC] && sess_pend_reg && !start_sess) ||
	                    (join_req && ctrl_reg[ASFB_CTRL_VERBOSE] && join_pend_reg && !start_join);

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			rcr_pend_reg <= 1'b0;
		end else if (rcr_req && !rcr_drop && (!rcr_pend_reg || start_rcr)) begin
			rcr_pend_reg <= 1'b1;
		end else if (start_rcr) begin
			rcr_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			rcr_fid_reg    <= 8'h00;
			rcr_src64_reg  <= 64'h0;
			rcr_src16_reg  <= 16'h0000;
			rcr_cmd_reg    <= 16'h0000;
			rcr_status_reg <= 8'h00;
			rcr_plen_reg   <= 4'h0;
			rcr_param_reg  <= 64'h0;
		end else if (rcr_req && !rcr_drop && (!rcr_pend_reg || start_rcr)) begin
			rcr_fid_reg    <= rcr_frame_id;
			rcr_src64_reg  <= rcr_src64;
			rcr_src16_reg  <= rcr_src16;
			rcr_cmd_reg    <= rcr_command;
			rcr_status_reg <= cmd_status_byte(rcr_status);
			rcr_plen_reg   <= rcr_query ? clamp_len(rcr_param_len) : 4'h0;
			rcr_param_reg  <= rcr_param;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sess_pend_reg <= 1'b0;
			sess_code_reg <= 8'h00;
			sess_addr_reg <= 64'h0;
			sess_tail_reg <= 24'h0;
			sess_len_reg  <= 16'h0000;
		end else if (sess_req && ctrl_reg[ASFB_CTRL_EXT_SEC] && (!sess_pend_reg || start_sess)) begin
			sess_pend_reg <= 1'b1;
			sess_addr_reg <= sess_addr;
			case (sess_kind)
				ASFB_SESS_UP_K: begin
					sess_code_reg <= ASFB_CODE_SESS_UP;
					sess_tail_reg <= {sess_options, sess_timeout};
					sess_len_reg  <= ASFB_LEN_SESS_UP;
				end
				ASFB_SESS_END_K: begin
					sess_code_reg <= ASFB_CODE_SESS_END;
					sess_tail_reg <= {reason_byte(sess_reason), 16'h0000};
					sess_len_reg  <= ASFB_LEN_SESS_OTHER;
				end
				default: begin
					sess_code_reg <= ASFB_CODE_AUTH_FAIL;
					sess_tail_reg <= {sess_error, 16'h0000};
					sess_len_reg  <= ASFB_LEN_SESS_OTHER;
				end
			endcase
		end else if (start_sess) begin
			sess_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			join_pend_reg <= 1'b0;
			join_code_reg <= 8'h00;
			join_len_reg  <= 4'h0;
			join_data_reg <= 64'h0;
		end else if (join_req && ctrl_reg[ASFB_CTRL_VERBOSE] && (!join_pend_reg || start_join)) begin
			join_pend_reg <= 1'b1;
			join_code_reg <= join_code;
			join_len_reg  <= clamp_len(join_len);
			join_data_reg <= join_data;
		end else if (start_join) begin
			join_pend_reg <= 1'b0;
		end
	end

	// ****************************************************************
	// frame sequencer
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			body_reg <= '0;
			len_reg  <= 16'h0000;
		end else if (start_rcr) begin
			body_reg <= {ASFB_TYPE_REMOTE, rcr_fid_reg, rcr_src64_reg, rcr_src16_reg,
			             rcr_cmd_reg, rcr_status_reg, rcr_param_reg, 8'h00};
			len_reg  <= ASFB_LEN_REMOTE + {12'h000, rcr_plen_reg};
		end else if (start_sess) begin
			body_reg <= {ASFB_TYPE_EXTSTAT, sess_code_reg, sess_addr_reg, sess_tail_reg,
			             {(BODY_W - 104){1'b0}}};
			len_reg  <= sess_len_reg;
		end else if (start_join) begin
			body_reg <= {ASFB_TYPE_EXTSTAT, join_code_reg, join_data_reg, {(BODY_W - 80){1'b0}}};
			len_reg  <= ASFB_LEN_JOIN + {12'h000, join_len_reg};
		end else if (state_reg == ST_BODY && em_can) begin
			body_reg <= {body_reg[BODY_W-9:0], 8'h00};
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			left_reg  <= 16'h0000;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (rcr_pend_reg || sess_pend_reg || join_pend_reg) begin
						state_reg <= ST_DELIM;
					end
				end
				ST_DELIM: begin
					if (em_can) begin
						state_reg <= ST_LEN_HI;
					end
				end
				ST_LEN_HI: begin
					if (em_can) begin
						state_reg <= ST_LEN_LO;
					end
				end
				ST_LEN_LO: begin
					if (em_can) begin
						state_reg <= ST_BODY;
						left_reg  <= len_reg;
					end
				end
				ST_BODY: begin
					if (em_can) begin
						left_reg <= left_reg - 16'h0001;
						if (left_reg == 16'h0001) begin
							state_reg <= ST_CSUM;
						end
					end
				end
				ST_CSUM: begin
					if (em_can) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	always_comb begin
		em_load  = 1'b0;
		em_byte  = 8'h00;
		em_add   = 1'b0;
		em_clear = 1'b0;
		case (state_reg)
			ST_IDLE: em_clear = 1'b1;
			ST_DELIM: begin
				em_load = 1'b1;
				em_byte = ASFB_DELIMITER;
			end
			ST_LEN_HI: begin
				em_load = 1'b1;
				em_byte = len_reg[15:8];
			end
			ST_LEN_LO: begin
				em_load = 1'b1;
				em_byte = len_reg[7:0];
			end
			ST_BODY: begin
				em_load = 1'b1;
				em_add  = 1'b1;
				em_byte = body_reg[BODY_W-1 -: 8];
			end
			ST_CSUM: begin
				em_load = 1'b1;
				em_byte = em_csum;
			end
			default: em_clear = 1'b1;
		endcase
	end

	assign frame_done = (state_reg == ST_CSUM) && em_can;

	asfb_byte_emitter u_emitter (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.load      (em_load),
		.byte_in   (em_byte),
		.add_sum   (em_add),
		.clear_sum (em_clear),
		.tx_ready  (tx_ready),
		.can_load  (em_can),
		.checksum  (em_csum),
		.tx_data   (tx_data),
		.tx_valid  (tx_valid)
	);

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			busy <= 1'b0;
		end else begin
			// the checksum byte may still wait on a stalled receiver after the sequencer is idle
			busy <= (state_reg != ST_IDLE) || rcr_pend_reg || sess_pend_reg || join_pend_reg ||
			        (tx_valid && !tx_ready);
		end
	end

	// ****************************************************************
	// register bus and interrupt
	// ****************************************************************
	assign events = {overrun, filt_drop, rcr_drop, frame_done};

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			ctrl_reg <= ASFB_CTRL_RESET;
			mask_reg <= ASFB_MASK_RESET;
		end else if (reg_wr) begin
			if (reg_addr == ASFB_OFS_CTRL) begin
				ctrl_reg <= reg_wdata[1:0];
			end
			if (reg_addr == ASFB_OFS_MASK) begin
				mask_reg <= reg_wdata[3:0];
			end
		end
	end

	// a new event wins over a write-one clear in the same cycle
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			status_reg <= 4'h0;
		end else if (reg_wr && reg_addr == ASFB_OFS_STATUS) begin
			status_reg <= (status_reg & ~reg_wdata[3:0]) | events;
		end else begin
			status_reg <= status_reg | events;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			count_reg <= 16'h0000;
		end else if (frame_done) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_reg & mask_reg);
		end
	end

	// unmapped offsets and idle cycles read as zero
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				ASFB_OFS_CTRL:   reg_rdata <= {30'h0, ctrl_reg};
				ASFB_OFS_STATUS: reg_rdata <= {28'h0, status_reg};
				ASFB_OFS_MASK:   reg_rdata <= {28'h0, mask_reg};
				ASFB_OFS_STATE:  reg_rdata <= {28'h0, join_pend_reg, sess_pend_reg, rcr_pend_reg,
				                               state_reg != ST_IDLE};
				ASFB_OFS_COUNT:  reg_rdata <= {16'h0, count_reg};
				default:         reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

endmodule

//--- testbench/asfb_frame_builder_assertions.sv
// checker for the serial api status frame builder
`timescale 1ns/1ps
module asfb_checker
	import asfb_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        reg_rd,
	input  wire logic [31:0] reg_rdata,
	input  wire logic [7:0]  tx_data,
	input  wire logic        tx_valid,
	input  wire logic        tx_ready,
	input  wire logic        busy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// ****
	// frame position tracker
	// ****
	logic       acc;
	logic [4:0] pos_reg;
	logic [7:0] len_reg;
	logic [7:0] sum_reg;
	logic [7:0] type_reg;
	assign acc = tx_valid && tx_ready;
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pos_reg <= 5'h0;
			len_reg <= 8'h0;
			sum_reg <= 8'h0;
			type_reg <= 8'h0;
		end else if (acc) begin
			pos_reg <= (pos_reg > 5'h2 && pos_reg == len_reg + 8'h3) ? 5'h0 : pos_reg + 5'h1;
			if (pos_reg == 5'h2)
				len_reg <= tx_data;
			if (pos_reg == 5'h3)
				type_reg <= tx_data;
			sum_reg <= (pos_reg < 5'h3) ? 8'h0 : sum_reg + tx_data;
		end
	end
	a_delim_first: assert property (acc && pos_reg == 5'h0 |-> tx_data == ASFB_DELIMITER)
		else $error("frame opened without delimiter");
	a_len_high: assert property (acc && pos_reg == 5'h1 |-> tx_data == 8'h0)
		else $error("length high byte wrong");
	a_csum_value: assert property (acc && pos_reg > 5'h3 && pos_reg == len_reg + 8'h3
			|-> tx_data == ASFB_CSUM_BASE - sum_reg)
		else $error("checksum byte wrong");
	a_frame_type: assert property (acc && pos_reg == 5'h3
			|-> tx_data == ASFB_TYPE_REMOTE || tx_data == ASFB_TYPE_EXTSTAT)
		else $error("unknown frame type");
	a_fid_nonzero: assert property (acc && pos_reg == 5'h4 && type_reg == ASFB_TYPE_REMOTE |-> tx_data != 8'h0)
		else $error("response sent for zero identifier");
	a_rcr_length: assert property (acc && pos_reg == 5'h3 && tx_data == ASFB_TYPE_REMOTE
			|-> len_reg >= 8'd15 && len_reg <= 8'd23)
		else $error("response length out of range");
	a_hold_byte: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("byte dropped before taken");
	a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	a_busy_frame: assert property (tx_valid |-> busy)
		else $error("byte offered while not busy");
endmodule
bind asfb_frame_builder asfb_checker chk_u (
	.mclk(mclk), .reset_n(reset_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .busy(busy)
);

//--- testbench/asfb_host_model.sv
// host side of the byte stream, with optional stalls
`timescale 1ns/1ps
module asfb_host_model
	import asfb_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire logic       slow,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	logic [7:0] got[$];
	logic [1:0] tick_reg;
	// ****
	// receiver
	// ****
	always @(posedge mclk) begin
		if (!reset_n) begin
			tick_reg <= 2'h0;
			tx_ready <= 1'b0;
		end else begin
			tick_reg <= tick_reg + 2'h1;
			tx_ready <= !slow || tick_reg == 2'h0;
			if (tx_valid && tx_ready && (got.size() != 0 || tx_data == ASFB_DELIMITER))
				got.push_back(tx_data);
		end
	end
endmodule

//--- testbench/test_api_status_frame_builder.sv
// self-checking bench for the serial api status frame builder
`timescale 1ns/1ps
module test_api_status_frame_builder
	import asfb_pkg::*;
;
	logic        mclk, reset_n, reg_wr, reg_rd, irq, rcr_req, rcr_query, sess_req, join_req;
	logic        tx_ready, tx_valid, busy, slow;
	logic [7:0]  reg_addr, rcr_frame_id, sess_options, sess_error, join_code, tx_data;
	logic [31:0] reg_wdata, reg_rdata;
	logic [63:0] rcr_src64, rcr_param, sess_addr, join_data;
	logic [15:0] rcr_src16, rcr_command, sess_timeout;
	logic [2:0]  rcr_status, sess_reason;
	logic [3:0]  rcr_param_len, join_len;
	logic [1:0]  sess_kind;
	logic [7:0]  body[$];
	int          failures, checks, seed, cyc;

	asfb_frame_builder dut_u (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
		.rcr_req, .rcr_frame_id, .rcr_src64, .rcr_src16, .rcr_command, .rcr_status, .rcr_query,
		.rcr_param_len, .rcr_param, .sess_req, .sess_kind, .sess_addr, .sess_options, .sess_timeout,
		.sess_reason, .sess_error, .join_req, .join_code, .join_len, .join_data, .tx_ready, .tx_data,
		.tx_valid, .busy);
	asfb_host_model host_u (.mclk, .reset_n, .slow, .tx_data, .tx_valid, .tx_ready);

	// ****
	// helpers
	// ****
	task automatic results;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		chk(reg_rdata, e);
		@(posedge mclk);
	endtask
	// most significant byte first
	task automatic put(input logic [63:0] v, input int n);
		for (int i = n - 1; i >= 0; i--)
			body.push_back(v[8 * i +: 8]);
	endtask
	function automatic logic [63:0] r64();
		return {$random(seed), $random(seed)};
	endfunction
	// kind 0 remote response, 1 secure session, 2 join progress
	task automatic run(input int kind, input logic on, input logic [7:0] p0, input logic [2:0] p1,
			input logic [3:0] p2);
		logic [63:0] w0, w1, w2;
		logic [7:0]  e[$];
		logic [7:0]  s;
		logic [3:0]  m;
		int          k;
		w0 = r64();
		w1 = r64();
		w2 = r64();
		m = p2 > 4'h8 ? 4'h8 : p2;
		slow <= w2[63];
		rcr_src64 <= w0;
		rcr_param <= w1;
		sess_addr <= w2;
		join_data <= {w1[31:0], w0[63:32]};
		rcr_src16 <= w2[15:0];
		rcr_command <= w2[31:16];
		sess_options <= w2[39:32];
		sess_timeout <= w2[55:40];
		sess_error <= w0[7:0];
		join_code <= w1[15:8];
		rcr_frame_id <= p0;
		rcr_query <= p0[7];
		sess_kind <= p0[1:0];
		rcr_status <= p1;
		sess_reason <= p1;
		rcr_param_len <= p2;
		join_len <= p2;
		rcr_req <= kind == 0;
		sess_req <= kind == 1;
		join_req <= kind == 2;
		@(posedge mclk);
		rcr_req <= 1'b0;
		sess_req <= 1'b0;
		join_req <= 1'b0;
		body = {};
		case (kind)
			0: begin
				body = {ASFB_TYPE_REMOTE, rcr_frame_id};
				put(rcr_src64, 8);
				put(rcr_src16, 2);
				put(rcr_command, 2);
				body.push_back(rcr_status > 3'h4 ? ASFB_CST_ERROR : {5'h0, rcr_status});
				if (rcr_query)
					put(rcr_param >> (64 - 8 * m), m);
			end
			1: begin
				body = {ASFB_TYPE_EXTSTAT, sess_kind == 2'h0 ? ASFB_CODE_SESS_UP :
					sess_kind == 2'h1 ? ASFB_CODE_SESS_END : ASFB_CODE_AUTH_FAIL};
				put(sess_addr, 8);
				if (sess_kind == 2'h0) begin
					body.push_back(sess_options);
					put(sess_timeout, 2);
				end else if (sess_kind == 2'h1)
					body.push_back(sess_reason > 3'h4 ? ASFB_RSN_PEER : {5'h0, sess_reason});
				else
					body.push_back(sess_error);
			end
			default: begin
				body = {ASFB_TYPE_EXTSTAT, join_code};
				put(join_data >> (64 - 8 * m), m);
			end
		endcase
		s = ASFB_CSUM_BASE;
		e = {ASFB_DELIMITER, 8'h00, 8'(body.size())};
		foreach (body[i]) begin
			e.push_back(body[i]);
			s -= body[i];
		end
		e.push_back(s);
		if (!on)
			e = {};
		k = 0;
		repeat (3) @(negedge mclk);
		while (busy !== 1'b0 && k < 400) begin
			@(negedge mclk);
			k++;
		end
		@(posedge mclk);
		chk(host_u.got.size(), e.size()); // frame present or not
		foreach (e[i]) chk(host_u.got[i], e[i]); // byte match
		host_u.got = {};
	endtask

	// ****
	// sequence
	// ****
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			results();
		end
	end
	initial begin
		seed = 55095;
		failures = 0;
		checks = 0;
		cyc = 0;
		reset_n = 1'b0;
		{reg_wr, reg_rd, rcr_req, sess_req, join_req, slow, rcr_query, reg_addr, reg_wdata} = '0;
		{rcr_frame_id, rcr_src64, rcr_src16, rcr_command, rcr_status, rcr_param_len, rcr_param} = '0;
		{sess_kind, sess_addr, sess_options, sess_timeout, sess_reason, sess_error} = '0;
		{join_code, join_len, join_data} = '0;
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		rd(ASFB_OFS_CTRL, {30'h0, ASFB_CTRL_RESET});
		rd(ASFB_OFS_MASK, {28'h0, ASFB_MASK_RESET});
		rd(8'h20, 32'h0);
		wr(ASFB_OFS_MASK, 32'h6);
		rd(ASFB_OFS_MASK, 32'h6);
		for (int i = 0; i < 8; i++) run(0, 1, {i[0], 7'(i + 1)}, 3'(i), 4'($random(seed)));
		run(0, 0, 8'h00, 3'h0, 4'h3); // zero identifier
		chk(irq, 32'h1);
		rd(ASFB_OFS_STATUS, 32'h3);
		wr(ASFB_OFS_STATUS, 32'hF);
		rd(ASFB_OFS_STATUS, 32'h0);
		chk(irq, 32'h0);
		run(1, 0, 8'h00, 3'h1, 4'h0); // session output off
		run(2, 0, 8'h00, 3'h0, 4'h4); // join output off
		rd(ASFB_OFS_STATUS, 32'h4);
		chk(irq, 32'h1);
		wr(ASFB_OFS_STATUS, 32'h4);
		wr(ASFB_OFS_CTRL, 32'h3);
		rd(ASFB_OFS_CTRL, 32'h3);
		for (int i = 0; i < 8; i++) run(1, 1, 8'(i), 3'(i), 4'h0);
		for (int i = 0; i < 4; i++) run(2, 1, 8'h0, 3'h0, 4'(3 * i + 2));
		rd(ASFB_OFS_STATE, 32'h0);
		rd(ASFB_OFS_COUNT, 32'd20);
		chk(irq, 32'h0);
		results();
	end
endmodule
